// ### rtl/add_exec_consts.svh
/*
 Constants for the addition execute block: opcode fields,
 flag positions and reset values.
 Assumes it is included by its bare name from the design module.
*/
//==========================================================================
// Overview of operation
// [RULE1] Literal opcode 0Fxx adds literal to accumulator
// [RULE2] Opcode 001001da ffffffff adds accumulator to file
// [RULE3] Destination bit picks accumulator or file register
// [RULE4] Access bit picks access bank or bank select
// [RULE5] Extended set, a=0, f<=5Fh: indexed offset mode
// [RULE6] One word, one cycle of four phases
// [RULE7] Sum sets negative, overflow, carry, digit carry, zero
`ifndef ADD_EXEC_CONSTS_SVH
`define ADD_EXEC_CONSTS_SVH

//==========================================================================
// Opcode fields
`define LIT_OPCODE_HI   8'h0F
`define FILE_OPCODE_HI  6'h09
`define DEST_BIT        9
`define ACCESS_BIT      8
`define INDEXED_MAX     8'h5F

//==========================================================================
// Flag positions in the 5-bit status field
`define FLAG_C   0
`define FLAG_NIBBLE_CARRY  1
`define FLAG_Z             2
`define FLAG_OVERFLOW      3
`define FLAG_N   4

//==========================================================================
// Reset values
`define ACC_RESET     8'h00
`define STATUS_RESET  5'h00

`endif

// ### rtl/add_exec_pkg.sv
/*
 Types for the addition execute block.
 Assumes the constants header sits beside it.
*/
package add_exec_pkg;
   // Quarter-cycle phases of one instruction cycle, one-hot
   typedef enum logic [3:0] {
      PH_DECODE  = 4'h1,
      PH_READ    = 4'h2,
      PH_PROCESS = 4'h4,
      PH_WRITE   = 4'h8
   } phase_t;
endpackage : add_exec_pkg

// ### rtl/add_exec.sv
/*
 Decode and execute of the two 8-bit addition instructions of the core.
 One clock edge stands for one quarter phase, so an addition takes four
 edges from decode to write; the indexed offset mode is only signalled,
 the offset itself is added by the address unit outside.
 Assumes a word is offered with instr_valid_i for one decode edge; the
 file memory answers the registered read address within the read phase,
 before the edge that ends it.
*/
`timescale 1ns/1ps
`include "add_exec_consts.svh"

module add_exec
   import add_exec_pkg::*;
(
   input  wire logic        clk_i,          // Core clock, 40 MHz
   input  wire logic        arst_n_i,       // Async reset, active low
   input  wire logic        instr_valid_i,  // Instruction word present
   input  wire logic [15:0] instr_i,        // Instruction word
   input  wire logic [3:0]  bank_select_register_i, // Bank select value
   input  wire logic        ext_set_en_i,   // Extended set enabled
   input  wire logic [7:0]  file_rdata_i,   // File read data
   output logic      [11:0] file_addr_o,    // File address
   output logic             file_rd_o,      // File read strobe
   output logic             file_wr_o,      // File write strobe
   output logic      [7:0]  file_wdata_o,   // File write data
   output logic             indexed_mode_o, // Indexed offset access
   output logic             access_bank_o,  // Access bank access
   output logic      [7:0]  acc_o,          // Working accumulator
   output logic      [4:0]  status_o,       // Sign ovf zero nibble carry
   output logic             done_o,         // Instruction retired
   output logic             illegal_o       // Word not an addition
);

   //=======================================================================
   // State
   typedef struct packed {
      phase_t      phase;     // Current quarter-cycle phase
      logic        is_lit;    // Word adds a literal
      logic        is_file;   // Word adds to a file register
      logic        dest_file; // Sum goes back to the file
      logic [7:0]  operand;   // Literal or file byte
      logic [8:0]  sum;       // Sum with carry out
      logic        half_c;    // Carry out of the low nibble
      logic        ovf;       // Signed overflow of the sum
      logic [11:0] addr;      // File address
      logic        rd;        // File read pulse
      logic        wr;        // File write pulse
      logic [7:0]  wdata;     // File write data
      logic        indexed;   // Indexed offset access
      logic        access;    // Access bank access
      logic [7:0]  acc;       // Working accumulator
      logic [4:0]  status;    // Flags
      logic        done;      // Retire pulse
      logic        illegal;   // Refused word pulse
   } state_t;

   state_t s_q;  // Registered state
   state_t s_d;  // Next state

   // Nibble sum gives the digit carry
   logic [4:0] nib_sum;

   //=======================================================================
   // Next-state logic
   always_comb begin
      s_d      = s_q;
      s_d.rd   = 1'b0;
      s_d.wr   = 1'b0;
      s_d.done = 1'b0;
      nib_sum  = {1'b0, s_q.acc[3:0]} + {1'b0, s_q.operand[3:0]};
      case (s_q.phase)
         PH_DECODE: begin
            // Idle here until a word arrives
            s_d.illegal = 1'b0;
            if (instr_valid_i) begin
               s_d.is_lit  = (instr_i[15:8] == `LIT_OPCODE_HI);    // RULE1
               s_d.is_file = (instr_i[15:10] == `FILE_OPCODE_HI);  // RULE2
               s_d.dest_file = instr_i[`DEST_BIT];                 // RULE3
               s_d.operand = instr_i[7:0];
               s_d.access  = ~instr_i[`ACCESS_BIT];
               s_d.indexed = 1'b0;
               if (instr_i[15:10] == `FILE_OPCODE_HI) begin
                  s_d.rd = 1'b1;
                  if (instr_i[`ACCESS_BIT]) begin
                     // Bank select supplies the upper address bits
                     s_d.addr = {bank_select_register_i,
                                 instr_i[7:0]};                    // RULE4
                  end else if (ext_set_en_i &&
                               instr_i[7:0] <= `INDEXED_MAX) begin
                     // Offset resolved by the address unit outside
                     s_d.indexed = 1'b1;                           // RULE5
                     s_d.addr    = {4'h0, instr_i[7:0]};
                  end else begin
                     s_d.addr = {4'h0, instr_i[7:0]};              // RULE4
                  end
               end
               if (instr_i[15:8] == `LIT_OPCODE_HI ||
                   instr_i[15:10] == `FILE_OPCODE_HI) begin
                  s_d.phase = PH_READ;                             // RULE6
               end else begin
                  // Not ours; flag it and stay in decode
                  s_d.illegal = 1'b1;
               end
            end
         end
         PH_READ: begin
            // File data arrives within the read phase, while the read strobe is high
            if (s_q.is_file) begin
               s_d.operand = file_rdata_i;
            end
            s_d.phase = PH_PROCESS;                                // RULE6
         end
         PH_PROCESS: begin
            s_d.sum = {1'b0, s_q.acc} + {1'b0, s_q.operand};       // RULE7
            // Carry out of bit 3 feeds the nibble flag
            s_d.half_c = nib_sum[4];                               // RULE7
            // Overflow: operands share a sign that the sum lost
            s_d.ovf    = (s_q.acc[7] == s_q.operand[7]) &&
                         (s_d.sum[7] != s_q.acc[7]);               // RULE7
            s_d.phase = PH_WRITE;                                  // RULE6
         end
         PH_WRITE: begin
            if (s_q.is_file && s_q.dest_file) begin
               s_d.wr    = 1'b1;                                   // RULE3
               s_d.wdata = s_q.sum[7:0];
            end else begin
               s_d.acc = s_q.sum[7:0];                             // RULE1
            end
            // Flags follow every addition, whichever way the sum went
            s_d.status[`FLAG_C]            = s_q.sum[8];         // RULE7
            s_d.status[`FLAG_NIBBLE_CARRY] = s_q.half_c;         // RULE7
            s_d.status[`FLAG_Z]            = (s_q.sum[7:0] == 8'h00); // RULE7
            s_d.status[`FLAG_OVERFLOW]     = s_q.ovf;            // RULE7
            s_d.status[`FLAG_N]            = s_q.sum[7];         // RULE7
            s_d.done  = 1'b1;
            s_d.phase = PH_DECODE;                                 // RULE6
         end
         default: begin
            // Recover from a corrupt phase code
            s_d.phase = PH_DECODE;
         end
      endcase
   end

   //=======================================================================
   // State register
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         // Constants only: phase takes its one-hot idle code
         s_q         <= '0;
         s_q.phase   <= PH_DECODE;
         s_q.acc     <= `ACC_RESET;
         s_q.status  <= `STATUS_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   //=======================================================================
   // Outputs straight from flip-flops
   assign file_addr_o    = s_q.addr;
   assign file_rd_o      = s_q.rd;
   assign file_wr_o      = s_q.wr;
   assign file_wdata_o   = s_q.wdata;
   assign indexed_mode_o = s_q.indexed;
   assign access_bank_o  = s_q.access;
   assign acc_o          = s_q.acc;
   assign status_o       = s_q.status;
   assign done_o         = s_q.done;
   assign illegal_o      = s_q.illegal;

   //=======================================================================
   // Checks
   // Operands for the flag checks come from earlier samples of the ports
   // where possible, so a slip in the adder or in the phase walk shows up
   // here at the retiring edge rather than instructions later.

   // A taken word retires exactly four edges after the take edge
   chk_four_phase_retire: assert property ( // RULE6
      @(posedge clk_i) disable iff (!arst_n_i)
      (s_q.phase == PH_DECODE && s_d.phase == PH_READ) |=> ##3 done_o)
      else $error("addition did not retire four phases after decode");

   // No retire pulse while the word is still in its first phases
   chk_no_early_done: assert property ( // RULE6
      @(posedge clk_i) disable iff (!arst_n_i)
      (s_q.phase == PH_DECODE && s_d.phase == PH_READ)
      |=> !done_o ##1 !done_o ##1 !done_o)
      else $error("addition retired before its write phase");

   // Words offered while busy are ignored; address and flag stay put
   chk_busy_addr_hold: assert property ( // RULE6
      @(posedge clk_i) disable iff (!arst_n_i)
      (s_q.phase != PH_DECODE) |=> ($stable(file_addr_o) && !illegal_o))
      else $error("word accepted while an addition was in flight");

   // The file read strobe is a single-cycle pulse
   chk_rd_one_shot: assert property ( // RULE6
      @(posedge clk_i) disable iff (!arst_n_i)
      file_rd_o |=> !file_rd_o)
      else $error("file read strobe longer than one cycle");

   // Literal sum lands in the accumulator at the write phase
   chk_lit_sum_acc: assert property ( // RULE1
      @(posedge clk_i) disable iff (!arst_n_i)
      (s_q.phase == PH_DECODE && instr_valid_i &&
       instr_i[15:8] == `LIT_OPCODE_HI)
      |=> ##3 (acc_o == $past(acc_o, 4) + $past(instr_i[7:0], 4)))
      else $error("literal sum not written to accumulator");

   // A literal word never touches the file memory
   chk_lit_no_read: assert property ( // RULE1
      @(posedge clk_i) disable iff (!arst_n_i)
      (s_q.phase == PH_DECODE && instr_valid_i &&
       instr_i[15:8] == `LIT_OPCODE_HI) |=> (!file_rd_o && !illegal_o))
      else $error("literal word read the file memory");

   // A word that is neither addition is flagged, reads no file and leaves the accumulator alone
   chk_illegal_quiet: assert property ( // RULE2
      @(posedge clk_i) disable iff (!arst_n_i)
      (s_q.phase == PH_DECODE && instr_valid_i &&
       instr_i[15:8] != `LIT_OPCODE_HI &&
       instr_i[15:10] != `FILE_OPCODE_HI)
      |=> (illegal_o && !file_rd_o && $stable(acc_o)))
      else $error("foreign word was not refused cleanly");

   // File sum goes out with the write strobe when d is set
   chk_dest_file_write: assert property ( // RULE3
      @(posedge clk_i) disable iff (!arst_n_i)
      (s_q.phase == PH_DECODE && instr_valid_i &&
       instr_i[15:10] == `FILE_OPCODE_HI && instr_i[`DEST_BIT])
      |=> ##3 file_wr_o)
      else $error("file destination not written");

   // The accumulator keeps its value when the file takes the sum
   chk_dest_acc_keep: assert property ( // RULE3
      @(posedge clk_i) disable iff (!arst_n_i)
      file_wr_o |-> $stable(acc_o))
      else $error("accumulator changed on file destination");

   // Written file data is the accumulator plus the byte read back
   chk_file_wdata: assert property ( // RULE2
      @(posedge clk_i) disable iff (!arst_n_i)
      file_wr_o |-> (file_wdata_o == $past(acc_o) + $past(file_rdata_i, 3)))
      else $error("file write data is not the sum");

   // A sum bound for the accumulator is the old value plus the operand
   chk_acc_dest: assert property ( // RULE3
      @(posedge clk_i) disable iff (!arst_n_i)
      (done_o && !file_wr_o) |-> (acc_o == $past(acc_o) + s_q.operand))
      else $error("accumulator destination not written with the sum");

   // The bank select value forms the upper address bits when a is set
   chk_bank_addr: assert property ( // RULE4
      @(posedge clk_i) disable iff (!arst_n_i)
      (s_q.phase == PH_DECODE && instr_valid_i &&
       instr_i[15:10] == `FILE_OPCODE_HI && instr_i[`ACCESS_BIT])
      |=> file_rd_o && file_addr_o[11:8] == $past(bank_select_register_i))
      else $error("bank select not used for banked access");

   // Access bank addresses carry zero upper bits
   chk_access_addr: assert property ( // RULE4
      @(posedge clk_i) disable iff (!arst_n_i)
      (file_rd_o && access_bank_o) |-> (file_addr_o[11:8] == 4'h0))
      else $error("access bank address has bank bits set");

   // Indexed offset only for access bank, extended set, low addresses
   chk_indexed_mode: assert property ( // RULE5
      @(posedge clk_i) disable iff (!arst_n_i)
      file_rd_o |-> (indexed_mode_o == (access_bank_o && $past(ext_set_en_i)
                     && file_addr_o[7:0] <= `INDEXED_MAX)))
      else $error("indexed mode decided wrongly");

   // Zero follows the byte that was written back
   chk_zero_flag: assert property ( // RULE7
      @(posedge clk_i) disable iff (!arst_n_i)
      done_o |-> (status_o[`FLAG_Z] ==
                  ((file_wr_o ? file_wdata_o : acc_o) == 8'h00)))
      else $error("zero flag wrong");

   // Carry out of bit 7 and the sign of the result
   chk_carry_flag: assert property ( // RULE7
      @(posedge clk_i) disable iff (!arst_n_i)
      done_o |-> (status_o[`FLAG_C] ==
                  ({1'b0, $past(acc_o)} + {1'b0, s_q.operand} > 9'h0FF) &&
                  status_o[`FLAG_N] ==
                  (file_wr_o ? file_wdata_o[7] : acc_o[7])))
      else $error("carry or negative flag wrong");

   // Carry out of the low nibble
   chk_nibble_carry: assert property ( // RULE7
      @(posedge clk_i) disable iff (!arst_n_i)
      done_o |-> (status_o[`FLAG_NIBBLE_CARRY] ==
                  ({1'b0, $past(acc_o[3:0])} + {1'b0, s_q.operand[3:0]}
                   > 5'h0F)))
      else $error("nibble carry flag wrong");

   // Signed overflow: like signs in, the other sign out
   chk_overflow_flag: assert property ( // RULE7
      @(posedge clk_i) disable iff (!arst_n_i)
      done_o |-> (status_o[`FLAG_OVERFLOW] ==
                  ($past(acc_o[7]) == s_q.operand[7] &&
                   (file_wr_o ? file_wdata_o[7] : acc_o[7]) !=
                   $past(acc_o[7]))))
      else $error("overflow flag wrong");

endmodule : add_exec

// ### bench/tb_add_exec.sv
/*
 Self-checking bench for add_exec: corner and random addition words.
 Assumes a word is taken at decode and retires four edges later.
*/
`timescale 1ns/1ps
module tb_add_exec;
   //=======================================================================
   // Signals
   logic        clk_i = 1'b0;                // 40 MHz core clock
   logic        arst_n_i = 1'b0;             // Reset, active low
   logic        instr_valid_i = 1'b0;        // Word present
   logic [15:0] instr_i = 16'h0000;          // Instruction word
   logic [3:0]  bank_select_register_i = 4'h0; // Bank for a=1
   logic        ext_set_en_i = 1'b0;         // Extended set on
   logic [7:0]  file_rdata_i = 8'h00;        // File read data
   logic [11:0] file_addr_o;                 // File address
   logic        file_rd_o;                   // File read pulse
   logic        file_wr_o;                   // File write pulse
   logic [7:0]  file_wdata_o;                // File write data
   logic        indexed_mode_o;              // Indexed offset access
   logic        access_bank_o;               // Access bank access
   logic [7:0]  acc_o;                       // Accumulator
   logic [4:0]  status_o;                    // Sign ovf zero nibble carry
   logic        done_o;                      // Retired pulse
   logic        illegal_o;                   // Not an addition
   logic [7:0]  acc_m;                       // Model accumulator
   int          miscompares = 0;             // Mismatch count
   int          comparisons = 0;             // Compare count

   always #12.5 clk_i = ~clk_i;

   add_exec u_add_exec (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .instr_valid_i(instr_valid_i), .instr_i(instr_i),
      .bank_select_register_i(bank_select_register_i),
      .ext_set_en_i(ext_set_en_i), .file_rdata_i(file_rdata_i),
      .file_addr_o(file_addr_o), .file_rd_o(file_rd_o),
      .file_wr_o(file_wr_o), .file_wdata_o(file_wdata_o),
      .indexed_mode_o(indexed_mode_o), .access_bank_o(access_bank_o),
      .acc_o(acc_o), .status_o(status_o), .done_o(done_o),
      .illegal_o(illegal_o));

   //=======================================================================
   // Checking helpers
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic close_out;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out

   // Flags of an 8-bit add: sign, overflow, zero, nibble carry, carry
   function automatic logic [4:0] flags(input logic [7:0] a, b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
              ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F, s[8]};
   endfunction : flags

   //=======================================================================
   // One instruction: drive, then check every visible effect
   task automatic exec(input logic [15:0] w, input logic [3:0] bk,
                       input logic e, input logic [7:0] fd);
      logic       lit, fop, d, a;
      logic [7:0] op, sum;
      int         n;
      lit = (w[15:8] == 8'h0F);
      fop = (w[15:10] == 6'h09);
      d = w[9];
      a = w[8];
      op = lit ? w[7:0] : fd;
      sum = acc_m + op;
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      instr_i <= w;
      bank_select_register_i <= bk;
      ext_set_en_i <= e;
      file_rdata_i <= fd;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      #1;
      chk("file_rd", file_rd_o, fop);
      chk("illegal", illegal_o, !(lit || fop));
      if (!(lit || fop)) begin
         // Refused words must leave the accumulator alone
         repeat (5) @(posedge clk_i);
         #1 chk("acc_kept", acc_o, acc_m);
         return;
      end
      if (fop) begin
         chk("addr", file_addr_o, a ? {bk, w[7:0]} : {4'h0, w[7:0]});
         chk("access", access_bank_o, !a);
         chk("indexed", indexed_mode_o, !a && e && w[7:0] <= 8'h5F);
      end
      // The take edge counts as the first of the four phases
      n = 1;
      while (done_o !== 1'b1 && n < 8) begin
         @(posedge clk_i);
         #1 n++;
      end
      if (n == 8) begin
         // Bounded wait ran out: count it and stop
         miscompares++;
         close_out();
      end else begin
         chk("latency", n, 4);
         chk("status", status_o, flags(acc_m, op));
         chk("file_wr", file_wr_o, fop && d);
         if (fop && d) chk("wdata", file_wdata_o, sum);
         else acc_m = sum;
         chk("acc", acc_o, acc_m);
      end
   endtask : exec

   //=======================================================================
   // Main sequence: corners first, then random words
   initial begin
      logic [31:0] r;
      logic [15:0] w;
      r = $urandom(32'h456282D5);
      acc_m = 8'h00;
      repeat (3) @(posedge clk_i);
      arst_n_i <= 1'b1;
      #1 chk("acc_rst", acc_o, 8'h00);
      chk("status_rst", status_o, 5'h00);
      // Overflow, carry and zero, digit carry, plain sum
      exec(16'h0F7F, 4'h0, 1'b0, 8'h00);
      exec(16'h0F01, 4'h0, 1'b0, 8'h00);
      exec(16'h0F80, 4'h0, 1'b0, 8'h00);
      exec(16'h0F08, 4'h0, 1'b0, 8'h00);
      exec(16'h0F08, 4'h0, 1'b0, 8'h00);
      exec(16'h0F15, 4'h0, 1'b0, 8'h00);
      // Indexed boundary, both destinations, banked access
      exec(16'h245F, 4'h3, 1'b1, 8'hF0);
      exec(16'h2660, 4'h3, 1'b1, 8'h01);
      exec(16'h27A5, 4'hA, 1'b1, 8'h7F);
      exec(16'h2400, 4'h5, 1'b0, 8'h00);
      exec(16'h0E12, 4'h0, 1'b0, 8'h00);
      exec(16'h2812, 4'h0, 1'b1, 8'h00);
      for (int i = 0; i < 60; i++) begin
         r = $urandom;
         w = r[0] ? {8'h0F, r[15:8]} : {6'h09, r[17:16], r[31:24]};
         exec(w, r[23:20], r[19], r[15:8]);
      end
      close_out();
   end
endmodule : tb_add_exec
